// ===== verilog/microstep_translator_pwm_ctrl.v
// translator, two-bridge off-time regulator and wishbone registers
`timescale 1ns/1ps
`include "microstep_consts.vh"

module microstep_translator_pwm_ctrl #(
   parameter TOFF_CYC  = `TOFF_NS / `CLK_NS,                  // off-time default
   parameter BLANK_CYC = (`BLANK_NS + `CLK_NS - 1) / `CLK_NS  // blank default
) (
   input  wire        clk_i,
   input  wire        rst_i,
   // wishbone classic slave
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [3:0]  adr_i,
   input  wire [3:0]  sel_i,
   input  wire [31:0] dat_i,
   output reg  [31:0] dat_o,
   output reg         ack_o,
   // controller pins
   input  wire        step_i,
   input  wire        dir_i,
   input  wire        resolution_select_lo_i,
   input  wire        resolution_select_hi_i,
   input  wire        reset_n_i,
   input  wire        enable_n_i,
   input  wire        sleep_n_i,
   input  wire        sync_rectify_disable_i,
   input  wire [7:0]  decay_fraction_input_i,
   // supervision inputs
   input  wire        supply_low_lockout_i,
   input  wire        overtemp_i,
   input  wire        pump_rail_low_i,
   input  wire        lowside_gate_rail_fault_i,
   // per-bridge analog feedback
   input  wire [1:0]  trip_i,
   input  wire [1:0]  zero_current_i,
   // outputs
   output reg         home_o,
   output wire        pump_enable_o,
   output reg  [15:0] dac_level_o,
   output reg  [1:0]  polarity_o,
   output reg  [3:0]  decay_mode_o,
   output reg  [1:0]  source_on_o,
   output reg  [1:0]  sink_on_o,
   output reg  [1:0]  rectify_on_o
);

   // ---------------------------------------------------------------
   // functions
   // ---------------------------------------------------------------
   // sine magnitude for k/16 of a quarter turn, full scale 255
   function [7:0] sine_mag;
      input [4:0] k;
      begin
         case (k)
            5'd0:    sine_mag = 8'h00;
            5'd1:    sine_mag = 8'h19;
            5'd2:    sine_mag = 8'h32;
            5'd3:    sine_mag = 8'h4A;
            5'd4:    sine_mag = 8'h62;
            5'd5:    sine_mag = 8'h78;
            5'd6:    sine_mag = 8'h8E;
            5'd7:    sine_mag = 8'hA2;
            5'd8:    sine_mag = 8'hB4;
            5'd9:    sine_mag = 8'hC5;
            5'd10:   sine_mag = 8'hD4;
            5'd11:   sine_mag = 8'hE1;
            5'd12:   sine_mag = 8'hEC;
            5'd13:   sine_mag = 8'hF4;
            5'd14:   sine_mag = 8'hFA;
            5'd15:   sine_mag = 8'hFE;
            default: sine_mag = 8'hFF;
         endcase
      end
   endfunction

   // magnitude of one phase at an index; ph 0 is cosine, 1 sine
   // the sine rises where the cosine falls, so one phase reads
   // the table forwards and the other backwards
   // the sign is handled by phase_pol
   function [7:0] phase_mag;
      input [5:0] idx;
      input       ph;
      reg   [4:0] q;
      begin
         q = {1'b0, idx[3:0]};
         if (idx[4] ^ ph) begin
            phase_mag = sine_mag(q);          // rising quarter
         end else begin
            phase_mag = sine_mag(5'h10 - q);  // falling quarter
         end
      end
   endfunction

   // polarity of one phase at an index, 1 means positive
   function phase_pol;
      input [5:0] idx;
      input       ph;
      begin
         if (ph) begin
            phase_pol = ~idx[5];
         end else begin
            phase_pol = ~(idx[5] ^ idx[4]);
         end
      end
   endfunction

   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   localparam NSYNC = 19;
   wire [NSYNC-1:0] raw_w;     // unsynchronised pins
   reg  [NSYNC-1:0] meta_q;    // first stage
   reg  [NSYNC-1:0] sync_q;    // second stage
   reg              step_d1_q; // delayed step for edge detect
   assign raw_w = {step_i, dir_i, resolution_select_lo_i,
                   resolution_select_hi_i, reset_n_i, enable_n_i,
                   sleep_n_i, sync_rectify_disable_i, supply_low_lockout_i,
                   overtemp_i, pump_rail_low_i, lowside_gate_rail_fault_i,
                   trip_i, zero_current_i, 3'h0};

   // two flops on every pin before any use
   // all pins share one delay, so direction and resolution
   // reach the edge detector together with the step pin
   // and keep the set-up and hold the controller gave them
   always @(posedge clk_i) begin
      if (rst_i) begin
         meta_q    <= {NSYNC{1'b0}};
         sync_q    <= {NSYNC{1'b0}};
         step_d1_q <= 1'b0;
      end else begin
         meta_q    <= raw_w;
         sync_q    <= meta_q;
         step_d1_q <= sync_q[18];
      end
   end

   // fraction code passes two flops as a word; slow-moving level
   // a torn word lasts one cycle on a filtered pin
   reg [7:0] pfd_meta_q;
   reg [7:0] pfd_q;
   always @(posedge clk_i) begin
      if (rst_i) begin
         pfd_meta_q <= 8'h00;
         pfd_q      <= 8'h00;
      end else begin
         pfd_meta_q <= decay_fraction_input_i;
         pfd_q      <= pfd_meta_q;
      end
   end

   wire       step_s  = sync_q[18];
   wire       dir_s   = sync_q[17];
   wire       ms_lo_s = sync_q[16];
   wire       ms_hi_s = sync_q[15];
   wire       rstn_s  = sync_q[14];
   wire       enn_s   = sync_q[13];
   wire       sleepn_s = sync_q[12];
   wire       srdis_s = sync_q[11];
   wire       supply_low_lockout_s  = sync_q[10];
   wire       fault_s = sync_q[9] | sync_q[8] | sync_q[7];
   wire [1:0] trip_s  = sync_q[6:5];
   wire [1:0] zero_s  = sync_q[4:3];

   // ---------------------------------------------------------------
   // global controls
   // ---------------------------------------------------------------
   // translator forced to Home by pin reset, lockout or sleep
   // the hold also puts the level outputs back to Home values
   wire hold_home = ~rstn_s | supply_low_lockout_s | ~sleepn_s;
   // power stage allowed only when nothing blocks it
   wire pwr_ok = rstn_s & ~enn_s & sleepn_s & ~fault_s & ~supply_low_lockout_s;
   wire step_rise = step_s & ~step_d1_q & ~hold_home;
   assign pump_enable_o = sleepn_s;

   // fraction pin classified into a decay mode
   // code 255 is the logic supply; both limits are strict,
   // so a code on a threshold gives mixed decay
   reg [1:0] pfd_mode;
   always @* begin
      if ({24'h0, pfd_q} * `PCT_SCALE > `PFD_HI_PCT * `PFD_FULL) begin
         pfd_mode = `DECAY_SLOW;
      end else if ({24'h0, pfd_q} * `PCT_SCALE < `PFD_LO_PCT * `PFD_FULL) begin
         pfd_mode = `DECAY_FAST;
      end else begin
         pfd_mode = `DECAY_MIXED;
      end
   end

   // increment picked by the resolution pins at the step edge
   // only step_rise makes use of it, so pins count only there
   reg [5:0] inc;
   always @* begin
      case ({ms_hi_s, ms_lo_s})
         2'b00:   inc = `INC_FULL;
         2'b01:   inc = `INC_HALF;
         2'b10:   inc = `INC_QUARTER;
         default: inc = `INC_SIXTEENTH;
      endcase
   end

   // ---------------------------------------------------------------
   // translator
   // ---------------------------------------------------------------
   reg  [5:0] idx_q;  // sixteenth-step position
   wire [5:0] idx_nx = dir_s ? idx_q + inc : idx_q - inc;

   // position index, wraps modulo 64 by its width
   // a step edge that comes while held at Home is lost,
   // not queued for later
   always @(posedge clk_i) begin
      if (rst_i || hold_home) begin
         idx_q <= `HOME_INDEX;
      end else if (step_rise) begin
         idx_q <= idx_nx;
      end
   end

   // levels, polarities and per-bridge decay modes
   // decay compares the new magnitude with the level still
   // on the output, the one the bridge regulates right now
   always @(posedge clk_i) begin
      if (rst_i || hold_home) begin
         dac_level_o  <= {phase_mag(`HOME_INDEX, 1'b1),
                          phase_mag(`HOME_INDEX, 1'b0)};
         polarity_o   <= {phase_pol(`HOME_INDEX, 1'b1),
                          phase_pol(`HOME_INDEX, 1'b0)};
         decay_mode_o <= {`DECAY_MIXED, `DECAY_MIXED};
      end else if (step_rise) begin
         dac_level_o  <= {phase_mag(idx_nx, 1'b1), phase_mag(idx_nx, 1'b0)};
         polarity_o   <= {phase_pol(idx_nx, 1'b1), phase_pol(idx_nx, 1'b0)};
         // lower level uses the fraction pin, else slow
         decay_mode_o[1:0] <= (phase_mag(idx_nx, 1'b0) < dac_level_o[7:0])
                              ? pfd_mode : `DECAY_SLOW;
         decay_mode_o[3:2] <= (phase_mag(idx_nx, 1'b1) < dac_level_o[15:8])
                              ? pfd_mode : `DECAY_SLOW;
      end
   end

   // home indicator low while the reset pin is held
   // lags the index by one edge; the level outputs move with it
   always @(posedge clk_i) begin
      if (rst_i) begin
         home_o <= 1'b0;
      end else begin
         home_o <= rstn_s & (idx_q == `HOME_INDEX);
      end
   end

   // ---------------------------------------------------------------
   // wishbone registers
   // ---------------------------------------------------------------
   reg  [15:0] offtime_q;  // off-time in clock cycles
   reg  [15:0] blank_q;    // blank time in clock cycles
   wire        req = cyc_i & stb_i & ~ack_o;          // new request
   wire        wr_go = cyc_i & stb_i & we_i & ack_o;  // write lands with ack
   wire [31:0] status_w = {10'h0, fault_s, pwr_ok, decay_mode_o,
                           polarity_o, home_o, 1'b0, idx_q, 6'h0};

   // single wait state answer, write on the ack edge
   // a request taken at one edge is answered at the next;
   // the master still holds address and data there, so the
   // write lands where the master sees ack, which then drops
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o     <= 1'b0;
         dat_o     <= 32'h0;
         offtime_q <= TOFF_CYC[15:0];
         blank_q   <= BLANK_CYC[15:0];
      end else begin
         ack_o <= req;
         dat_o <= 32'h0;
         if (wr_go && adr_i == `REG_OFFTIME) begin
            if (sel_i[0]) offtime_q[7:0]  <= dat_i[7:0];
            if (sel_i[1]) offtime_q[15:8] <= dat_i[15:8];
         end
         if (wr_go && adr_i == `REG_BLANK) begin
            if (sel_i[0]) blank_q[7:0]  <= dat_i[7:0];
            if (sel_i[1]) blank_q[15:8] <= dat_i[15:8];
         end
         if (req && !we_i) begin
            case (adr_i)
               `REG_OFFTIME: dat_o <= {16'h0, offtime_q};
               `REG_BLANK:   dat_o <= {16'h0, blank_q};
               `REG_STATUS:  dat_o <= status_w;
               default:      dat_o <= 32'h0;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // per-bridge current regulator
   // ---------------------------------------------------------------
   // a bridge drives until its comparator trips outside
   // blanking, then sits out the off-time with the source open;
   // the sink follows the decay mode, and mixed decay turns
   // from fast to slow as the timer passes the fraction level
   localparam ST_DRIVE = 1'b0;  // diagonal pair on
   localparam ST_OFF   = 1'b1;  // off-time running

   genvar b;
   generate
      for (b = 0; b < 2; b = b + 1) begin : g_bridge
         reg        st_q;     // drive or off
         reg [15:0] off_q;    // off-time remaining
         reg [15:0] blk_q;    // blanking remaining
         reg        zero_q;   // zero current seen this off period
         wire [1:0] mode = decay_mode_o[2*b+1:2*b];
         // timer level above fraction level keeps mixed in fast
         wire [31:0] lvl_l = {16'h0, off_q} * (`PFD_HI_PCT * `PFD_FULL);
         wire [31:0] lvl_r = {24'h0, pfd_q} * `PCT_SCALE * {16'h0, offtime_q};
         wire fast_now = (mode == `DECAY_FAST) ||
                         (mode == `DECAY_MIXED && lvl_l > lvl_r);

         // trip, off-time and blanking sequencing
         // blanking restarts at each switch-on, so diode
         // recovery ringing can not end the drive at once
         always @(posedge clk_i) begin
            if (rst_i || !pwr_ok) begin
               st_q   <= ST_DRIVE;
               off_q  <= 16'h0;
               blk_q  <= blank_q;
               zero_q <= 1'b0;
            end else begin
               case (st_q)
                  ST_DRIVE: begin
                     if (blk_q != 16'h0) begin
                        blk_q <= blk_q - 16'h1;
                     end else if (trip_s[b]) begin
                        st_q   <= ST_OFF;
                        off_q  <= offtime_q;
                        zero_q <= 1'b0;
                     end
                  end
                  ST_OFF: begin
                     if (zero_s[b]) zero_q <= 1'b1;
                     if (off_q <= 16'h1) begin
                        st_q  <= ST_DRIVE;
                        blk_q <= blank_q;
                     end else begin
                        off_q <= off_q - 16'h1;
                     end
                  end
                  default: st_q <= ST_DRIVE;
               endcase
            end
         end

         // switch commands, all off whenever power is blocked
         // registered one edge behind the state: glitch free,
         // at the cost of one cycle of delay
         // the rectifier stays off once zero current is seen,
         // so the winding never conducts backwards
         always @(posedge clk_i) begin
            if (rst_i || !pwr_ok) begin
               source_on_o[b]  <= 1'b0;
               sink_on_o[b]    <= 1'b0;
               rectify_on_o[b] <= 1'b0;
            end else if (st_q == ST_DRIVE) begin
               source_on_o[b]  <= 1'b1;
               sink_on_o[b]    <= 1'b1;
               rectify_on_o[b] <= 1'b0;
            end else begin
               source_on_o[b]  <= 1'b0;
               sink_on_o[b]    <= ~fast_now;
               rectify_on_o[b] <= ~srdis_s & ~zero_q & ~zero_s[b];
            end
         end
      end
   endgenerate

endmodule // microstep_translator_pwm_ctrl

// ===== pkg/microstep_consts.vh
// constants of the microstepping translator and current regulator
`ifndef MICROSTEP_CONSTS_VH
`define MICROSTEP_CONSTS_VH
// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define REG_OFFTIME    4'h0
`define REG_BLANK      4'h4
`define REG_STATUS     4'h8
// ----------------------------------------------------------------
// translator
// ----------------------------------------------------------------
`define HOME_INDEX     6'h08
`define INC_FULL       6'h10
`define INC_HALF       6'h08
`define INC_QUARTER    6'h04
`define INC_SIXTEENTH  6'h01
// ----------------------------------------------------------------
// decay modes
// ----------------------------------------------------------------
`define DECAY_SLOW     2'h0
`define DECAY_FAST     2'h1
`define DECAY_MIXED    2'h2
// fraction thresholds as percent of full scale
`define PFD_HI_PCT     32'h3C
`define PFD_LO_PCT     32'h15
`define PCT_SCALE      32'h64
`define PFD_FULL       32'hFF
// ----------------------------------------------------------------
// timing defaults in ns
// ----------------------------------------------------------------
`define TOFF_NS        38000
`define BLANK_NS       950
`define CLK_NS         4
`endif

// ===== sim/microstep_translator_pwm_ctrl_checker.sv
// checker of the output rules of the translator and bridge regulator
`timescale 1ns/1ps
`include "microstep_consts.vh"
module microstep_translator_pwm_ctrl_checker (
   input wire       clk_i,
   input wire       rst_i,
   input wire       reset_n_i,
   input wire       enable_n_i,
   input wire       sleep_n_i,
   input wire       sync_rectify_disable_i,
   input wire       supply_low_lockout_i,
   input wire       overtemp_i,
   input wire       pump_rail_low_i,
   input wire       lowside_gate_rail_fault_i,
   input wire       home_o,
   input wire       pump_enable_o,
   input wire [3:0] decay_mode_o,
   input wire [1:0] source_on_o,
   input wire [1:0] sink_on_o,
   input wire [1:0] rectify_on_o
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   wire fault_c = overtemp_i | pump_rail_low_i | lowside_gate_rail_fault_i;  // any fault pin
   wire off_c = fault_c | enable_n_i | supply_low_lockout_i | ~sleep_n_i | ~reset_n_i;
   wire dark = (source_on_o == 2'h0) && (sink_on_o == 2'h0);  // both bridges off
   reg       src0_was_q;   // bridge 0 source one edge ago
   reg [1:0] mode0_was_q;  // bridge 0 decay mode one edge ago
   // previous-edge copies for the trip detector
   always @(posedge clk_i) begin
      src0_was_q  <= source_on_o[0];
      mode0_was_q <= decay_mode_o[1:0];
   end
   wire trip_fall = src0_was_q && !source_on_o[0] && !off_c &&
                    (mode0_was_q == decay_mode_o[1:0]);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   property p_enable; enable_n_i [*6] |-> dark; endproperty
   a_enable: assert property (p_enable) else $error("bridge on while disabled");
   property p_fault; fault_c [*6] |-> dark; endproperty
   a_fault: assert property (p_fault) else $error("bridge on during fault");
   property p_reset_pin; !reset_n_i [*6] |-> dark && !home_o; endproperty
   a_reset_pin: assert property (p_reset_pin) else $error("reset pin ignored");
   property p_sleep; !sleep_n_i [*6] |-> dark && !pump_enable_o; endproperty
   a_sleep: assert property (p_sleep) else $error("active while asleep");
   property p_lockout; supply_low_lockout_i [*6] |-> dark; endproperty
   a_lockout: assert property (p_lockout) else $error("bridge on in lockout");
   property p_rect; sync_rectify_disable_i [*6] |-> rectify_on_o == 2'h0; endproperty
   a_rect: assert property (p_rect) else $error("rectifier on while disabled");
   property p_rect_decay; rectify_on_o[0] |-> !source_on_o[0]; endproperty
   a_rect_decay: assert property (p_rect_decay) else $error("rectifier during drive");
   property p_blank; $rose(source_on_o[0]) |-> (source_on_o[0] || off_c) [*3]; endproperty
   a_blank: assert property (p_blank) else $error("trip seen inside blanking");
   property p_offtime; trip_fall |-> !source_on_o[0] [*8]; endproperty
   a_offtime: assert property (p_offtime) else $error("off-time cut short");
   property p_slow; trip_fall && decay_mode_o[1:0] == `DECAY_SLOW |-> sink_on_o[0]; endproperty
   a_slow: assert property (p_slow) else $error("sink off in slow decay");
   property p_fast; trip_fall && decay_mode_o[1:0] == `DECAY_FAST |-> !sink_on_o[0]; endproperty
   a_fast: assert property (p_fast) else $error("sink on in fast decay");
   property p_reset_mode; $fell(rst_i) |-> decay_mode_o == 4'hA; endproperty
   a_reset_mode: assert property (p_reset_mode) else $error("reset mode not mixed");
   // main scenarios
   c_trip: cover property (trip_fall);
   c_drive: cover property ($rose(source_on_o[1]));
   c_rect: cover property (rectify_on_o[0]);
endmodule // microstep_translator_pwm_ctrl_checker

bind microstep_translator_pwm_ctrl microstep_translator_pwm_ctrl_checker checker_inst (
   .clk_i(clk_i), .rst_i(rst_i), .reset_n_i(reset_n_i), .enable_n_i(enable_n_i),
   .sleep_n_i(sleep_n_i), .sync_rectify_disable_i(sync_rectify_disable_i),
   .supply_low_lockout_i(supply_low_lockout_i), .overtemp_i(overtemp_i),
   .pump_rail_low_i(pump_rail_low_i), .lowside_gate_rail_fault_i(lowside_gate_rail_fault_i),
   .home_o(home_o), .pump_enable_o(pump_enable_o), .decay_mode_o(decay_mode_o),
   .source_on_o(source_on_o), .sink_on_o(sink_on_o), .rectify_on_o(rectify_on_o));

// ===== sim/step_ctrl_model.sv
// step and direction controller model driving the translator pins
`timescale 1ns/1ps
module step_ctrl_model #(
   parameter int SETUP_CYC = 50,   // 200 ns set-up and hold
   parameter int HI_CYC    = 250,  // 1.0 us step high
   parameter int LO_CYC    = 250   // 1.0 us step low
) (
   input  wire       clk_i,
   input  wire       go_i,
   input  wire       dir_req_i,
   input  wire [1:0] res_req_i,
   output logic      step_o,
   output logic      dir_o,
   output logic      res_lo_o,
   output logic      res_hi_o,
   output logic      busy_o
);
   // one step per request; pins scrambled once the hold time is over
   initial begin
      {step_o, dir_o, res_lo_o, res_hi_o, busy_o} = 5'h00;
      forever begin
         @(posedge clk_i);
         if (go_i) begin
            busy_o <= 1'b1;
            dir_o <= dir_req_i;
            {res_hi_o, res_lo_o} <= res_req_i;
            repeat (SETUP_CYC) @(posedge clk_i);
            step_o <= 1'b1;
            repeat (HI_CYC) @(posedge clk_i);
            step_o <= 1'b0;
            repeat (SETUP_CYC) @(posedge clk_i);
            {dir_o, res_hi_o, res_lo_o} <= ~{dir_o, res_hi_o, res_lo_o};
            repeat (LO_CYC) @(posedge clk_i);
            busy_o <= 1'b0;
         end
      end
   end
endmodule // step_ctrl_model

// ===== sim/tb_microstep_translator_pwm_ctrl.sv
// self-checking bench of the translator and bridge regulator
`timescale 1ns/1ps
`include "microstep_consts.vh"
module tb_microstep_translator_pwm_ctrl;
   localparam int TOFF = 20;   // shortened off-time
   localparam int BLANK = 4;   // shortened blank time
   localparam int WAKE = 300;  // shortened wake wait after sleep
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [3:0]  adr_i = 4'h0, sel_i = 4'h0, decay_mode_o;
   logic [31:0] dat_i = 32'h0, dat_o, q;
   logic        ack_o, home_o, pump_enable_o, step_i, dir_i, res_lo, res_hi, busy;
   logic        reset_n_i = 1'b1, enable_n_i = 1'b0, sleep_n_i = 1'b1, rect_off = 1'b0;
   logic        lock = 1'b0, go = 1'b0, dir_r = 1'b0;
   logic [2:0]  flt = 3'h0;  // overtemp, pump rail, gate rail
   logic [7:0]  code = 8'h00;
   logic [1:0]  trip_i = 2'h0, zero_current_i = 2'h0, res_r = 2'h0;
   logic [1:0]  polarity_o, source_on_o, sink_on_o, rectify_on_o;
   logic [15:0] dac_level_o, rnd = 16'h0033;
   logic [5:0]  idx = `HOME_INDEX;  // expected translator index
   logic [7:0]  corners [6] = '{8'h00, 8'h35, 8'h36, 8'h99, 8'h9A, 8'hFF};
   int          failures = 0, n_compared = 0, k, n;
   microstep_translator_pwm_ctrl #(.TOFF_CYC(TOFF), .BLANK_CYC(BLANK))
   microstep_translator_pwm_ctrl_inst (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .step_i(step_i),
      .dir_i(dir_i), .resolution_select_lo_i(res_lo), .resolution_select_hi_i(res_hi),
      .reset_n_i(reset_n_i), .enable_n_i(enable_n_i), .sleep_n_i(sleep_n_i),
      .sync_rectify_disable_i(rect_off), .decay_fraction_input_i(code),
      .supply_low_lockout_i(lock), .overtemp_i(flt[0]), .pump_rail_low_i(flt[1]),
      .lowside_gate_rail_fault_i(flt[2]), .trip_i(trip_i), .zero_current_i(zero_current_i),
      .home_o(home_o), .pump_enable_o(pump_enable_o), .dac_level_o(dac_level_o),
      .polarity_o(polarity_o), .decay_mode_o(decay_mode_o), .source_on_o(source_on_o),
      .sink_on_o(sink_on_o), .rectify_on_o(rectify_on_o));
   step_ctrl_model step_ctrl_model_inst (.clk_i(clk_i), .go_i(go), .dir_req_i(dir_r),
      .res_req_i(res_r), .step_o(step_i), .dir_o(dir_i), .res_lo_o(res_lo),
      .res_hi_o(res_hi), .busy_o(busy));
   // ----------------------------------------------------------------
   // clock, random source and analog feedback
   // ----------------------------------------------------------------
   initial forever #2 clk_i = ~clk_i;
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   always @(posedge clk_i) begin
      rnd <= lfsr(rnd);
      trip_i <= rnd[1:0];
      zero_current_i <= rnd[3:2];
   end
   // ----------------------------------------------------------------
   // expectations and tasks
   // ----------------------------------------------------------------
   function automatic logic [5:0] inc(input logic [1:0] r);
      case (r)
         2'h0: return `INC_FULL;
         2'h1: return `INC_HALF;
         2'h2: return `INC_QUARTER;
         default: return `INC_SIXTEENTH;
      endcase
   endfunction
   function automatic int mag(input logic [5:0] i, input bit ph);
      real v;
      v = ph ? $sin(3.14159265 * i / 32.0) : $cos(3.14159265 * i / 32.0);
      return $rtoi(255.0 * (v < 0 ? -v : v) + 0.5);
   endfunction
   function automatic logic [1:0] emode(input logic [5:0] o, nx, input bit ph,
                                        input logic [7:0] c);
      if (mag(nx, ph) >= mag(o, ph)) return `DECAY_SLOW;
      if (c * `PCT_SCALE > `PFD_HI_PCT * `PFD_FULL) return `DECAY_SLOW;
      if (c * `PCT_SCALE < `PFD_LO_PCT * `PFD_FULL) return `DECAY_FAST;
      return `DECAY_MIXED;
   endfunction
   task automatic print_verdict;
      if (failures == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge clk_i);
   endtask
   task automatic wb(input logic w, input logic [3:0] a, s, input logic [31:0] d);
      int i;
      cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; sel_i <= s; dat_i <= d;
      for (i = 0; i < 20 && ack_o !== 1'b1; i++) @(posedge clk_i);
      if (i == 20) begin failures++; print_verdict; end
      q = dat_o;
      cyc_i <= 1'b0; stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   // one random step; en tells whether the translator may move
   task automatic do_step(input bit en);
      logic d;
      logic [1:0] r;
      logic [5:0] nx;
      logic [7:0] c;
      int i;
      d = rnd[4]; r = rnd[6:5];
      c = rnd[7] ? corners[rnd[10:8] % 6] : rnd[15:8];
      nx = d ? idx + inc(r) : idx - inc(r);
      code <= c; rect_off <= rnd[11]; dir_r <= d; res_r <= r; go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      @(posedge clk_i);
      for (i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge clk_i);
      if (i == 2000) begin failures++; print_verdict; end
      tick(8);
      if (en) begin
         chk(decay_mode_o, {emode(idx, nx, 1'b1, c), emode(idx, nx, 1'b0, c)});
         chk(dac_level_o, {8'(mag(nx, 1'b1)), 8'(mag(nx, 1'b0))});
         chk(polarity_o, {nx < 6'd32, nx < 6'd16 || nx >= 6'd48});
         idx = nx;
      end else idx = `HOME_INDEX;
      wb(1'b0, 4'h8, 4'hF, 32'h0);
      chk(q[11:6], idx);
      chk(home_o, idx == `HOME_INDEX && reset_n_i);
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      tick(4);
      rst_i <= 1'b0;
      tick(6);
      chk(decay_mode_o, {`DECAY_MIXED, `DECAY_MIXED});
      chk({home_o, polarity_o, dac_level_o}, 19'h7B4B4);
      wb(1'b0, 4'h0, 4'hF, 32'h0);
      chk(q, TOFF);
      wb(1'b1, 4'h4, 4'h2, 32'hFFFF_12FF);
      wb(1'b0, 4'h4, 4'hF, 32'h0);
      chk(q, 32'h1200 | BLANK);
      wb(1'b1, 4'h4, 4'h3, BLANK);
      wb(1'b1, 4'h8, 4'hF, 32'hFFFF_FFFF);  // read-only place
      wb(1'b0, 4'hC, 4'hF, 32'h0);          // unmapped place
      chk(q, 32'h0);
      repeat (30) do_step(1'b1);
      // reset pin, sleep and lockout each return to Home
      for (k = 0; k < 3; k++) begin
         do_step(1'b1);
         reset_n_i <= (k != 0); sleep_n_i <= (k != 1); lock <= (k == 2);
         tick(8);
         do_step(1'b0);
         chk({source_on_o, sink_on_o, pump_enable_o}, {4'h0, k != 1});
         reset_n_i <= 1'b1; sleep_n_i <= 1'b1; lock <= 1'b0;
         tick(WAKE);
         chk(home_o, 1'b1);
      end
      // each fault, then output disable with the translator still running
      for (k = 0; k < 4; k++) begin
         enable_n_i <= (k == 3); flt <= (k < 3) ? 3'h1 << k : 3'h0;
         if (k == 3) do_step(1'b1);
         else tick(12);
         chk({source_on_o, sink_on_o}, 4'h0);
         enable_n_i <= 1'b0; flt <= 3'h0;
         for (n = 0; n < 40 && source_on_o === 2'h0; n++) @(posedge clk_i);
         chk(n < 40, 1'b1);
      end
      print_verdict;
   end
endmodule // tb_microstep_translator_pwm_ctrl
